// ===== verilog/pcrs_seq.sv
// Contract
// RQ1 - Double-rate output runs exactly twice the main clock frequency.
// RQ2 - Inverted output is the main clock shifted half a period.
// RQ3 - Half-rate clock toggles each main period, used as loop feedback.
// RQ4 - Main clocks fixed at twice the reference frequency.
// RQ5 - Loop enable high locks; low gives static test mode, any frequency.
// RQ6 - Source keeps reference between minimum and quarter of double-rate maximum.
// RQ7 - Request high at power-up holds reset output low until lock.
// RQ8 - After power-up lock, wait 1024 main cycles then release.
// RQ9 - Request low at power-up keeps reset output low while low.
// RQ10 - Request rising after startup low releases 1024 main cycles later.
// RQ11 - Locked low request pulse drives output low for 1024 main cycles.
// RQ12 - Clocks keep running and locked while reset output is low.
// RQ13 - Reset output open drain: only pulls low or floats.
// RQ14 - Counter counts main rises, restarts on new request or lost lock.
//
// Top of the clock driver digital side with processor reset sequencer.
// Assumes ref_clk_i is a 10 MHz system clock; pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module pcrs_seq #(
	parameter int HOLD_CYCLES = pcrs_pkg::RST_HOLD_CYCLES
) (
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Board pins
	input wire logic sync_ref_i,
	input wire logic rst_req_i,
	input wire logic loop_en_i,
	// Clock outputs
	output logic [2:0] main_clock_outs_o,
	output logic inverted_clock_out_o,
	output logic double_rate_clock_out_o,
	output logic half_rate_clock_o,
	// Reset/lock open drain
	output logic rst_lock_o,
	output logic rst_lock_oe_n_o
);
	logic sync_m_ff;
	logic sync_s_ff;
	logic sync_d_ff;
	logic req_m_ff;
	logic req_s_ff;
	logic en_m_ff;
	logic en_s_ff;
	logic [pcrs_pkg::PHASE_W-1:0] phase;
	logic [2:0] main_ff;
	logic inv_ff;
	logic dbl_ff;
	logic half_out_ff;
	logic oe_n_ff;
	logic [10:0] cnt_ff;
	pcrs_pkg::pcrs_state_t state_ff;
	pcrs_pkg::pcrs_state_t nxt_state;
	pcrs_clk_if clk_bus ();

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_m_ff <= 1'b0;
			sync_s_ff <= 1'b0;
			sync_d_ff <= 1'b0;
			req_m_ff <= 1'b0;
			req_s_ff <= 1'b0;
			en_m_ff <= 1'b0;
			en_s_ff <= 1'b0;
		end else if (ce_i) begin
			sync_m_ff <= sync_ref_i;
			sync_s_ff <= sync_m_ff;
			sync_d_ff <= sync_s_ff;
			req_m_ff <= rst_req_i;
			req_s_ff <= req_m_ff;
			en_m_ff <= loop_en_i;
			en_s_ff <= en_m_ff;
		end
	end

	pcrs_clkgen u_clkgen (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.ref_rise_i(sync_s_ff && !sync_d_ff),
		.loop_en_i(en_s_ff),
		.phase_o(phase),
		.clk_bus(clk_bus.gen)
	);

	// ----------------------------------------
	// Clock outputs
	// ----------------------------------------
	// Outputs keep running in every reset state; test mode makes them follow the reference
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			main_ff <= 3'h0;
			inv_ff <= 1'b1;
			dbl_ff <= 1'b0;
			half_out_ff <= 1'b0;
		end else if (ce_i) begin
			if (!en_s_ff) begin
				// Static test mode: outputs follow the reference directly
				main_ff <= {3{sync_s_ff}}; // RQ5
				inv_ff <= ~sync_s_ff;
				dbl_ff <= sync_s_ff;
				half_out_ff <= sync_s_ff;
			end else begin
				main_ff <= {3{phase[1]}}; // RQ12
				inv_ff <= ~phase[1]; // RQ2
				dbl_ff <= phase[0]; // RQ1
				half_out_ff <= clk_bus.half_clk; // RQ3
			end
		end
	end

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			pcrs_pkg::PCRS_ACQUIRE: begin
				if (!req_s_ff) begin
					nxt_state = pcrs_pkg::PCRS_HOLD; // RQ9
				end else if (clk_bus.locked) begin
					nxt_state = pcrs_pkg::PCRS_COUNT; // RQ7
				end
			end
			pcrs_pkg::PCRS_HOLD: begin
				if (req_s_ff) begin
					nxt_state = pcrs_pkg::PCRS_COUNT; // RQ10
				end
			end
			pcrs_pkg::PCRS_COUNT: begin
				if (!req_s_ff) begin
					nxt_state = pcrs_pkg::PCRS_HOLD; // RQ14
				end else if (!clk_bus.locked) begin
					nxt_state = pcrs_pkg::PCRS_ACQUIRE; // RQ14
				end else if (clk_bus.main_rise && cnt_ff == 11'(HOLD_CYCLES - 1)) begin
					nxt_state = pcrs_pkg::PCRS_RUN; // RQ8
				end
			end
			pcrs_pkg::PCRS_RUN: begin
				if (!req_s_ff) begin
					nxt_state = pcrs_pkg::PCRS_HOLD; // RQ11
				end else if (!clk_bus.locked) begin
					nxt_state = pcrs_pkg::PCRS_ACQUIRE;
				end
			end
			default: begin
				nxt_state = pcrs_pkg::PCRS_ACQUIRE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= pcrs_pkg::PCRS_ACQUIRE;
		end else if (ce_i) begin
			state_ff <= nxt_state;
		end
	end

	// Count main-clock rises only while counting; any exit restarts from zero
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff <= 11'h000;
		end else if (ce_i) begin
			if (state_ff != pcrs_pkg::PCRS_COUNT || nxt_state != pcrs_pkg::PCRS_COUNT) begin
				cnt_ff <= 11'h000; // RQ14
			end else if (clk_bus.main_rise) begin
				cnt_ff <= cnt_ff + 11'h001; // RQ11
			end
		end
	end

	// Pin is only ever pulled low or released; pull-up gives the high level
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			oe_n_ff <= pcrs_pkg::RST_OE_N_RST;
		end else if (ce_i) begin
			oe_n_ff <= nxt_state == pcrs_pkg::PCRS_RUN; // RQ13
		end
	end

	assign main_clock_outs_o = main_ff;
	assign inverted_clock_out_o = inv_ff;
	assign double_rate_clock_out_o = dbl_ff;
	assign half_rate_clock_o = half_out_ff;
	assign rst_lock_o = 1'b0;
	assign rst_lock_oe_n_o = oe_n_ff;
endmodule
`default_nettype wire

// ===== inc/pcrs_pkg.sv
// Constants shared by the clock and reset sequencer design files.
// Assumes a single 10 MHz system clock domain.
package pcrs_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int REF_CLK_MHZ = 10;
	localparam int RST_HOLD_CYCLES = 1024;
	localparam int RST_HOLD_REF_CYCLES = 512;
	localparam int RST_MIN_PULSE_NS = 10;
	localparam int RST_MIN_PULSE_CYC = (RST_MIN_PULSE_NS * REF_CLK_MHZ + 999) / 1000 < 1 ? 1 :
		(RST_MIN_PULSE_NS * REF_CLK_MHZ + 999) / 1000;
	localparam int LOCK_EDGES = 4;
	localparam int PHASE_W = 2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0] PHASE_RST = 2'h0;
	localparam logic RST_OE_N_RST = 1'b0;

	typedef enum logic [3:0] {
		PCRS_ACQUIRE = 4'h1,
		PCRS_HOLD = 4'h2,
		PCRS_COUNT = 4'h4,
		PCRS_RUN = 4'h8
	} pcrs_state_t;

endpackage

// ===== inc/pcrs_clk_if.sv
// Carries the main-rise strobe, half clock and lock flag between the clock generator and the sequencer.
// Assumes both ends share ref_clk_i.
`timescale 1ns/10ps
`default_nettype none
interface pcrs_clk_if;
	logic main_rise;
	logic half_clk;
	logic locked;
	modport gen (output main_rise, output half_clk, output locked);
	modport seq (input main_rise, input half_clk, input locked);
endinterface
`default_nettype wire

// ===== verilog/pcrs_clkgen.sv
// Digital model of the loop: derives the phase that pcrs_seq decodes into the main, inverted and double clocks, and the half clock.
// Assumes the reference period is two main periods, eight system clocks.
`timescale 1ns/10ps
`default_nettype none
module pcrs_clkgen (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Control
	input wire logic ref_rise_i,
	input wire logic loop_en_i,
	// Derived clocks
	output logic [pcrs_pkg::PHASE_W-1:0] phase_o,
	pcrs_clk_if.gen clk_bus
);
	logic [pcrs_pkg::PHASE_W-1:0] phase_ff;
	logic half_ff;
	logic [2:0] lock_cnt_ff;

	// ----------------------------------------
	// Phase counter: one reference period is two main periods
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_ff <= pcrs_pkg::PHASE_RST;
		end else if (ce_i) begin
			if (ref_rise_i) begin
				phase_ff <= 2'h1; // RQ4
			end else begin
				phase_ff <= phase_ff + 2'h1;
			end
		end
	end

	// Half-rate clock toggles once per main period and is the loop feedback;
	// a reference rise pulls its rising edge into line
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			half_ff <= 1'b0;
		end else if (ce_i) begin
			if (ref_rise_i) begin
				half_ff <= 1'b1; // RQ3
			end else if (phase_ff == 2'h3) begin
				half_ff <= ~half_ff; // RQ3
			end
		end
	end

	// Lock: a run of reference rises that find the feedback at its wrap point.
	// A reference whose period is not a whole multiple of two main periods keeps the count at zero.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lock_cnt_ff <= 3'h0;
		end else if (ce_i) begin
			if (!loop_en_i) begin
				lock_cnt_ff <= 3'h0; // RQ5
			end else if (ref_rise_i && phase_ff == 2'h0 && half_ff) begin
				if (lock_cnt_ff != 3'(pcrs_pkg::LOCK_EDGES)) begin
					lock_cnt_ff <= lock_cnt_ff + 3'h1; // RQ4
				end
			end else if (ref_rise_i) begin
				lock_cnt_ff <= 3'h0; // RQ4
			end
		end
	end

	assign phase_o = phase_ff;
	assign clk_bus.main_rise = ce_i && phase_ff == 2'h3;
	assign clk_bus.half_clk = half_ff;
	assign clk_bus.locked = lock_cnt_ff == 3'(pcrs_pkg::LOCK_EDGES);
endmodule
`default_nettype wire

// ===== tb/pcrs_seq_asserts.sv
// Checker for the sequencer pins.
// Assumes one clock domain; bound to every pcrs_seq.
`timescale 1ns/10ps
`default_nettype none
module pcrs_seq_asserts #(
	parameter int HOLD_CYCLES = pcrs_pkg::RST_HOLD_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic rst_req_i,
	input wire logic loop_en_i,
	input wire logic [2:0] main_clock_outs_o,
	input wire logic inverted_clock_out_o,
	input wire logic double_rate_clock_out_o,
	input wire logic half_rate_clock_o,
	input wire logic rst_lock_o,
	input wire logic rst_lock_oe_n_o
);
	logic main_d_ff;
	int rises_ff;
	int quiet_ff;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// Raw request clears early, so this count of main rises can only run ahead
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			main_d_ff <= 1'b0;
			rises_ff <= 0;
		end else begin
			main_d_ff <= main_clock_outs_o[0];
			if (!rst_req_i) begin
				rises_ff <= 0;
			end else if (main_clock_outs_o[0] && !main_d_ff) begin
				rises_ff <= rises_ff + 1;
			end
		end
	end
	// Enabled cycles since the loop pin went high; the outputs need a few to settle
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			quiet_ff <= 0;
		end else if (!loop_en_i) begin
			quiet_ff <= 0;
		end else if (ce_i && quiet_ff < 15) begin
			quiet_ff <= quiet_ff + 1;
		end
	end
	outs_equal_a: assert property (&main_clock_outs_o || ~|main_clock_outs_o)
		else $error("Main outputs differ");
	inv_phase_a: assert property (inverted_clock_out_o == !main_clock_outs_o[0])
		else $error("Inverted output not opposite");
	dbl_rate_a: assert property (quiet_ff > 5 && $rose(main_clock_outs_o[0])
		|-> $fell(double_rate_clock_out_o)) else $error("Double rate out of step");
	half_slow_a: assert property (quiet_ff > 5 && rst_lock_oe_n_o && $changed(half_rate_clock_o)
		|=> ($stable(half_rate_clock_o) || quiet_ff == 0)[*3]) else $error("Half rate too fast");
	drain_zero_a: assert property (rst_lock_o == 1'b0) else $error("Pin driven high");
	req_low_a: assert property ((!rst_req_i && ce_i)[*4] |-> !rst_lock_oe_n_o)
		else $error("Pin released during request");
	test_low_a: assert property ((!loop_en_i && ce_i)[*8] |-> !rst_lock_oe_n_o)
		else $error("Pin released in test mode");
	hold_count_a: assert property ($rose(rst_lock_oe_n_o) |-> rises_ff >= HOLD_CYCLES)
		else $error("Pin released early");
	clk_run_a: assert property ((loop_en_i && ce_i)[*8] |-> $changed(main_clock_outs_o[0])
		|| $changed(double_rate_clock_out_o)) else $error("Clocks stopped");
	cover property ($rose(rst_lock_oe_n_o));
	cover property ($fell(rst_lock_oe_n_o));
	cover property ($fell(loop_en_i));
endmodule
bind pcrs_seq pcrs_seq_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (.ref_clk_i, .rst_i, .ce_i,
	.rst_req_i, .loop_en_i, .main_clock_outs_o, .inverted_clock_out_o, .double_rate_clock_out_o,
	.half_rate_clock_o, .rst_lock_o, .rst_lock_oe_n_o);
`default_nettype wire

// ===== tb/pcrs_ref_src.sv
// Board reference source and the pull-up on the reset line.
// Assumes the bench clock; changes on falling edges.
`timescale 1ns/10ps
`default_nettype none
module pcrs_ref_src (
	input wire logic ref_clk_i,
	input wire logic rst_lock_o,
	input wire logic rst_lock_oe_n_o,
	output logic sync_ref_o,
	output logic rst_pin_o
);
	logic [2:0] div_ff = 3'h0;
	// Eighth rate square wave: half the main rate, a quarter of the double rate
	always @(negedge ref_clk_i) div_ff <= div_ff + 3'h1;
	assign sync_ref_o = div_ff[2];
	assign rst_pin_o = rst_lock_oe_n_o ? 1'b1 : rst_lock_o;
endmodule
`default_nettype wire

// ===== tb/pcrs_seq_tb.sv
// Bench for the clock and reset sequencer.
// Assumes the reference source model and a short hold count.
`timescale 1ns/10ps
`default_nettype none
module pcrs_seq_tb;
	localparam int HOLD = 8;
	logic ref_clk_i = 0, rst_i = 1, rst_req_i = 1, loop_en_i = 1, ce_i = 1;
	logic sync_ref, pin, lock_d, oe_n, inv, dbl, half;
	logic [2:0] mains;
	logic [1:0] exp_q[$];
	logic [1:0] e;
	int fail_count = 0, checked = 0, rises = 0;
	logic last_pin = 0, last_main = 0, last_req = 1;
	always #50 ref_clk_i = ~ref_clk_i;
	pcrs_seq #(.HOLD_CYCLES(HOLD)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.sync_ref_i(sync_ref), .rst_req_i(rst_req_i), .loop_en_i(loop_en_i),
		.main_clock_outs_o(mains), .inverted_clock_out_o(inv), .double_rate_clock_out_o(dbl),
		.half_rate_clock_o(half), .rst_lock_o(lock_d), .rst_lock_oe_n_o(oe_n));
	pcrs_ref_src u_src (.ref_clk_i(ref_clk_i), .rst_lock_o(lock_d), .rst_lock_oe_n_o(oe_n),
		.sync_ref_o(sync_ref), .rst_pin_o(pin));
	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic results;
		$display("Checked %0d, errors %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wait_pin(input logic lvl);
		int n;
		n = 0;
		while (pin !== lvl && n < 400) begin
			@(negedge ref_clk_i);
			n++;
		end
		cmp("pin wait", lvl, pin);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	// Monitor: pin edges take the oldest note; bit 1 asks for a rise count check
	always @(posedge ref_clk_i) begin
		#1;
		if (last_req === 1'b0 && rst_req_i === 1'b1) rises = 0;
		else if (mains[0] === 1'b1 && last_main === 1'b0) rises++;
		if (pin !== last_pin) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : {1'b0, last_pin};
			cmp("reset pin", e[0], pin);
			if (e[1]) cmp("hold rises", 1, rises >= HOLD - 1 && rises <= HOLD + 1);
		end
		last_pin = pin;
		last_main = mains[0];
		last_req = rst_req_i;
	end
	initial begin
		int w;
		void'($urandom(6038));
		cyc(4);
		rst_i = 0;
		exp_q.push_back(2'h1);
		wait_pin(1);
		repeat (3) begin
			w = 3 + $urandom_range(5);
			exp_q.push_back(2'h0);
			exp_q.push_back(2'h3);
			rst_req_i = 0;
			cyc(w);
			rst_req_i = 1;
			wait_pin(1);
		end
		// Freeze mid-count for whole reference periods, so the loop stays in step
		exp_q.push_back(2'h0);
		exp_q.push_back(2'h3);
		rst_req_i = 0;
		cyc(4);
		rst_req_i = 1;
		cyc(10);
		ce_i = 0;
		cyc(8 * (1 + $urandom_range(1)));
		ce_i = 1;
		wait_pin(1);
		exp_q.push_back(2'h0);
		exp_q.push_back(2'h3);
		rst_req_i = 0;
		cyc(4);
		rst_req_i = 1;
		cyc(2 * HOLD);
		rst_req_i = 0;
		cyc(60);
		rst_req_i = 1;
		wait_pin(1);
		exp_q.push_back(2'h0);
		exp_q.push_back(2'h1);
		loop_en_i = 0;
		cyc(20);
		loop_en_i = 1;
		wait_pin(1);
		// Mid-run reset with the request low: pin waits for the request
		exp_q.push_back(2'h0);
		exp_q.push_back(2'h3);
		rst_i = 1;
		rst_req_i = 0;
		cyc(2);
		rst_i = 0;
		cyc(100);
		rst_req_i = 1;
		wait_pin(1);
		cyc(5);
		cmp("notes left", 0, exp_q.size());
		results();
	end
	initial begin
		#500000;
		fail_count++;
		results();
	end
endmodule
`default_nettype wire
